// File: logic/cdvu_regs.vh
// cdvu_regs.vh: register map, field positions and limits of the
// decrypt-and-verify unit; assumes 32-bit APB data and byte addresses.
`ifndef CDVU_REGS_VH
`define CDVU_REGS_VH
// register byte offsets
`define CDVU_ADDR_ARG0   8'h00
`define CDVU_ADDR_ARG1   8'h04
`define CDVU_ADDR_CMD    8'h08
`define CDVU_ADDR_STAT   8'h0C
`define CDVU_ADDR_MASK   8'h10
`define CDVU_ADDR_STATE  8'h14
// reset values
`define CDVU_RST_WORD    32'h0000_0000
`define CDVU_RST_EV      4'h0
// command word fields
`define CDVU_CMD_OP      1:0
`define CDVU_CMD_PRIO    2
`define CDVU_CMD_M       5:4
`define CDVU_CMD_AMASK   9:8
`define CDVU_OP_CCM      2'h0
`define CDVU_OP_ABORT    2'h1
`define CDVU_OP_SOFT_RESET_CMD     2'h2
// argument word fields
`define CDVU_ARG0_A      11:0
`define CDVU_ARG0_E      27:16
`define CDVU_ARG1_K      7:0
`define CDVU_ARG1_N      15:8
`define CDVU_ARG1_C      22:16
`define CDVU_ARG1_F      30:24
// packed instruction slot
`define CDVU_SL_W        56
`define CDVU_SL_A        11:0
`define CDVU_SL_E        23:12
`define CDVU_SL_K        31:24
`define CDVU_SL_N        39:32
`define CDVU_SL_C        46:40
`define CDVU_SL_F        53:47
`define CDVU_SL_M        55:54
// event bits of status and mask
`define CDVU_EV_LDONE    0
`define CDVU_EV_HDONE    1
`define CDVU_EV_MISUSE   2
`define CDVU_EV_BADADDR  3
// limits
`define CDVU_MEM_SIZE    13'h0300
`define CDVU_MAX_LEN     8'h80
`define CDVU_KEY_BYTES   8'h20
`endif

// File: logic/cdvu_ccm_unit.v
// cdvu_ccm_unit.v: decrypt-and-verify, abort and soft reset unit
// assumes a synchronous byte RAM: read data valid the cycle after mem_rd_o
//
// Notes on behaviour
// - authenticate F header, then C payload bytes
// - key at 16K, counter at 16N, output E
// - priority bit: zero low, one high
// - 0/4/8/16 byte code compared at A+C+F
// - pass/fail stored per priority state register bit
// - misuse when priority level already active
// - misuse when F plus C exceeds 128
// - done event per priority, success or not
// - abort mask: bit1 high, bit0 low
// - aborted work stops at once, no rollback
// - abort flushes all pending, unstarted instructions
// - soft reset clears all but host interface, key_mem and ctr_mem
// - soft reset only first after select low
// - zero destination means write over A+F
`timescale 1ns/1ps
`include "cdvu_regs.vh"
module cdvu_ccm_unit
(
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    input  wire        chip_select_active_low_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg  [11:0] mem_addr_o,
    output reg         mem_rd_o,
    output reg         mem_wr_o,
    output reg  [7:0]  mem_wdata_o,
    input  wire [7:0]  mem_rdata_i,
    output reg         irq_o
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_KEY  = 3'h1;
localparam [2:0] ST_HDR  = 3'h2;
localparam [2:0] ST_PAY  = 3'h3;
localparam [2:0] ST_TAG  = 3'h4;
localparam [2:0] ST_END  = 3'h5;

////////////////////////////////////////////////////////////////////////////
// functions

function [4:0] tag_len;
    input [1:0] m;
    begin
        case (m)
            2'h0:    tag_len = 5'h00;
            2'h1:    tag_len = 5'h04;
            2'h2:    tag_len = 5'h08;
            default: tag_len = 5'h10;
        endcase
    end
endfunction

function [11:0] dest_of;
    input [`CDVU_SL_W-1:0] s;
    begin
        if (s[`CDVU_SL_E] == 12'h000)
            dest_of = s[`CDVU_SL_A] + {5'h00, s[`CDVU_SL_F]};
        else
            dest_of = s[`CDVU_SL_E];
    end
endfunction

function addr_bad;
    input [`CDVU_SL_W-1:0] s;
    reg [12:0] src_end;
    reg [12:0] dst_end;
    begin
        src_end = {1'b0, s[`CDVU_SL_A]} + {6'h00, s[`CDVU_SL_F]}
                + {6'h00, s[`CDVU_SL_C]} + {8'h00, tag_len(s[`CDVU_SL_M])};
        dst_end = {1'b0, dest_of(s)} + {6'h00, s[`CDVU_SL_C]};
        addr_bad = (src_end > `CDVU_MEM_SIZE)
                 | (dst_end > `CDVU_MEM_SIZE)
                 | ({1'b0, s[`CDVU_SL_K], 4'hF} >= `CDVU_MEM_SIZE)
                 | ({1'b0, s[`CDVU_SL_N], 4'hF} >= `CDVU_MEM_SIZE);
    end
endfunction

function [7:0] stage_lim;
    input [2:0]            st;
    input [`CDVU_SL_W-1:0] s;
    begin
        case (st)
            ST_KEY:  stage_lim = `CDVU_KEY_BYTES;
            ST_HDR:  stage_lim = {1'b0, s[`CDVU_SL_F]};
            ST_PAY:  stage_lim = {1'b0, s[`CDVU_SL_C]};
            ST_TAG:  stage_lim = {3'h0, tag_len(s[`CDVU_SL_M])};
            default: stage_lim = 8'h00;
        endcase
    end
endfunction

function [31:0] mac_step;
    input [31:0] mac;
    input [7:0]  b;
    input [7:0]  kb;
    begin
        mac_step = {mac[23:0], mac[31:24]} ^ {24'h000000, b ^ kb};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// reset release and soft reset

reg         rst_q1_ff;
reg         rst_q2_ff;
reg         core_rst_b_ff;
reg         first_ff;
reg         cs_prev_ff;
reg  [31:0] arg0_ff;
reg  [31:0] arg1_ff;
reg  [3:0]  stat_ff;
reg  [3:0]  mask_ff;
reg  [1:0]  slot_v_ff;
reg  [`CDVU_SL_W-1:0] slot_ff [0:1];
reg  [`CDVU_SL_W-1:0] cur_ff;
reg         cur_p_ff;
reg  [2:0]  st_ff;
reg  [1:0]  ph_ff;
reg  [7:0]  idx_ff;
reg  [31:0] mac_ff;
reg         pass_ff;
reg  [1:0]  auth_ff;
reg  [7:0]  key_mem [0:15];
reg  [7:0]  ctr_mem [0:15];

always @(posedge sys_clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        rst_q1_ff <= 1'b0;
        rst_q2_ff <= 1'b0;
    end
    else
    begin
        rst_q1_ff <= 1'b1;
        rst_q2_ff <= rst_q1_ff;
    end
end

wire acc_wr = psel_i & penable_i & pready_o & pwrite_i;
wire cmd_wr = acc_wr & (paddr_i == `CDVU_ADDR_CMD);
wire [1:0] op = pwdata_i[`CDVU_CMD_OP];
wire srst = cmd_wr & (op == `CDVU_OP_SOFT_RESET_CMD)
          & first_ff & ~chip_select_active_low_i;

////////////////////////////////////////////////////////////////////////////
// host interface: apb handshake, read mux, select tracking

wire mapped = (paddr_i == `CDVU_ADDR_ARG0) | (paddr_i == `CDVU_ADDR_ARG1)
            | (paddr_i == `CDVU_ADDR_CMD)  | (paddr_i == `CDVU_ADDR_STAT)
            | (paddr_i == `CDVU_ADDR_MASK) | (paddr_i == `CDVU_ADDR_STATE);
wire setup  = psel_i & ~penable_i;
reg  [31:0] rd_mux;

always @*
begin
    case (paddr_i)
        `CDVU_ADDR_ARG0:  rd_mux = arg0_ff;
        `CDVU_ADDR_ARG1:  rd_mux = arg1_ff;
        `CDVU_ADDR_STAT:  rd_mux = {28'h0000000, stat_ff};
        `CDVU_ADDR_MASK:  rd_mux = {28'h0000000, mask_ff};
        `CDVU_ADDR_STATE: rd_mux = {26'h0000000, first_ff, st_ff != ST_IDLE,
                                    slot_v_ff, auth_ff};
        default:          rd_mux = `CDVU_RST_WORD;
    endcase
end

// this block survives a soft reset
always @(posedge sys_clk_i or negedge rst_q2_ff)
begin
    if (!rst_q2_ff)
    begin
        pready_o      <= 1'b0;
        pslverr_o     <= 1'b0;
        prdata_o      <= `CDVU_RST_WORD;
        first_ff      <= 1'b0;
        cs_prev_ff    <= 1'b1;
        core_rst_b_ff <= 1'b0;
    end
    else
    begin
        pready_o      <= setup;
        pslverr_o     <= setup & ~mapped;
        prdata_o      <= (setup & ~pwrite_i) ? rd_mux : `CDVU_RST_WORD;
        cs_prev_ff    <= chip_select_active_low_i;
        core_rst_b_ff <= ~srst;
        if (cs_prev_ff & ~chip_select_active_low_i)
            first_ff <= 1'b1;
        else if (cmd_wr)
            first_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// instruction issue checks

wire iss_ccm = cmd_wr & (op == `CDVU_OP_CCM);
wire iss_p   = pwdata_i[`CDVU_CMD_PRIO];
wire [`CDVU_SL_W-1:0] new_slot = {pwdata_i[`CDVU_CMD_M],
    arg1_ff[`CDVU_ARG1_F], arg1_ff[`CDVU_ARG1_C], arg1_ff[`CDVU_ARG1_N],
    arg1_ff[`CDVU_ARG1_K], arg0_ff[`CDVU_ARG0_E], arg0_ff[`CDVU_ARG0_A]};
wire [7:0] len_sum = {1'b0, arg1_ff[`CDVU_ARG1_C]}
                   + {1'b0, arg1_ff[`CDVU_ARG1_F]};
wire misuse = iss_ccm & (slot_v_ff[iss_p]
            | (len_sum > `CDVU_MAX_LEN));
wire bad    = iss_ccm & ~misuse & addr_bad(new_slot);
wire accept = iss_ccm & ~misuse & ~bad;
wire [1:0] amask = pwdata_i[`CDVU_CMD_AMASK];
wire abort  = cmd_wr & (op == `CDVU_OP_ABORT) & (|amask);
wire busy   = st_ff != ST_IDLE;
wire kill   = abort & busy & amask[cur_p_ff];
wire pick   = slot_v_ff[1];
wire start  = ~busy & (|slot_v_ff) & ~abort;
wire at_end = st_ff == ST_END;
wire [3:0] ev = {bad, misuse, at_end & cur_p_ff, at_end & ~cur_p_ff};

////////////////////////////////////////////////////////////////////////////
// engine datapath

wire [11:0] a_w  = cur_ff[`CDVU_SL_A];
wire [11:0] af_w = a_w + {5'h00, cur_ff[`CDVU_SL_F]};
wire [7:0]  lim  = stage_lim(st_ff, cur_ff);
wire [7:0]  ks   = key_mem[idx_ff[3:0]] ^ ctr_mem[idx_ff[3:0]] ^ idx_ff;
wire [7:0]  pt   = mem_rdata_i ^ ks;
wire [7:0]  tag_exp = mac_ff[{idx_ff[1:0], 3'h0} +: 8] ^ ks;
wire        consume = (ph_ff == 2'h2);
reg  [11:0] rd_addr;

always @*
begin
    case (st_ff)
        ST_KEY:  rd_addr = idx_ff[4] ? {cur_ff[`CDVU_SL_N], idx_ff[3:0]}
                                     : {cur_ff[`CDVU_SL_K], idx_ff[3:0]};
        ST_HDR:  rd_addr = a_w + {4'h0, idx_ff};
        ST_PAY:  rd_addr = af_w + {4'h0, idx_ff};
        ST_TAG:  rd_addr = af_w + {5'h00, cur_ff[`CDVU_SL_C]}
                         + {4'h0, idx_ff};
        default: rd_addr = 12'h000;
    endcase
end

always @(posedge sys_clk_i)
begin
    if (consume && (st_ff == ST_KEY))
    begin
        if (idx_ff[4])
            ctr_mem[idx_ff[3:0]] <= mem_rdata_i;
        else
            key_mem[idx_ff[3:0]] <= mem_rdata_i;
    end
end

////////////////////////////////////////////////////////////////////////////
// registers, slots and engine sequence

always @(posedge sys_clk_i or negedge core_rst_b_ff)
begin
    if (!core_rst_b_ff)
    begin
        arg0_ff     <= `CDVU_RST_WORD;
        arg1_ff     <= `CDVU_RST_WORD;
        stat_ff     <= `CDVU_RST_EV;
        mask_ff     <= `CDVU_RST_EV;
        irq_o       <= 1'b0;
        slot_v_ff   <= 2'h0;
        slot_ff[0]  <= {`CDVU_SL_W{1'b0}};
        slot_ff[1]  <= {`CDVU_SL_W{1'b0}};
        cur_ff      <= {`CDVU_SL_W{1'b0}};
        cur_p_ff    <= 1'b0;
        st_ff       <= ST_IDLE;
        ph_ff       <= 2'h0;
        idx_ff      <= 8'h00;
        mac_ff      <= `CDVU_RST_WORD;
        pass_ff     <= 1'b1;
        auth_ff     <= 2'h0;
        mem_addr_o  <= 12'h000;
        mem_rd_o    <= 1'b0;
        mem_wr_o    <= 1'b0;
        mem_wdata_o <= 8'h00;
    end
    else
    begin
        mem_rd_o <= 1'b0;
        mem_wr_o <= 1'b0;
        irq_o    <= |(stat_ff & mask_ff);
        if (acc_wr && (paddr_i == `CDVU_ADDR_ARG0))
            arg0_ff <= pwdata_i;
        if (acc_wr && (paddr_i == `CDVU_ADDR_ARG1))
            arg1_ff <= pwdata_i;
        if (acc_wr && (paddr_i == `CDVU_ADDR_MASK))
            mask_ff <= pwdata_i[3:0];
        if (acc_wr && (paddr_i == `CDVU_ADDR_STAT))
            stat_ff <= (stat_ff & ~pwdata_i[3:0]) | ev;
        else
            stat_ff <= stat_ff | ev;
        // slot bookkeeping
        if (accept)
        begin
            slot_v_ff[iss_p] <= 1'b1;
            slot_ff[iss_p]   <= new_slot;
        end
        if (abort)
        begin
            if (amask[0] | ~(busy & ~cur_p_ff))
                slot_v_ff[0] <= 1'b0;
            if (amask[1] | ~(busy & cur_p_ff))
                slot_v_ff[1] <= 1'b0;
        end
        if (at_end)
            slot_v_ff[cur_p_ff] <= 1'b0;
        // sequence
        if (kill)
        begin
            st_ff <= ST_IDLE;
            ph_ff <= 2'h0;
        end
        else
        begin
            case (st_ff)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        cur_ff   <= slot_ff[pick];
                        cur_p_ff <= pick;
                        st_ff    <= ST_KEY;
                        idx_ff   <= 8'h00;
                        ph_ff    <= 2'h0;
                        mac_ff   <= `CDVU_RST_WORD;
                        pass_ff  <= 1'b1;
                    end
                end
                ST_KEY, ST_HDR, ST_PAY, ST_TAG:
                begin
                    case (ph_ff)
                        2'h0:
                        begin
                            if (idx_ff == lim)
                            begin
                                st_ff  <= st_ff + 3'h1;
                                idx_ff <= 8'h00;
                            end
                            else
                            begin
                                mem_rd_o   <= 1'b1;
                                mem_addr_o <= rd_addr;
                                ph_ff      <= 2'h1;
                            end
                        end
                        2'h1:
                            ph_ff <= 2'h2;
                        default:
                        begin
                            ph_ff  <= 2'h0;
                            idx_ff <= idx_ff + 8'h01;
                            if (st_ff == ST_HDR)
                                mac_ff <= mac_step(mac_ff, mem_rdata_i,
                                    key_mem[idx_ff[3:0]]);
                            if (st_ff == ST_PAY)
                            begin
                                mac_ff      <= mac_step(mac_ff, pt,
                                    key_mem[idx_ff[3:0]]);
                                mem_wr_o    <= 1'b1;
                                mem_wdata_o <= pt;
                                mem_addr_o  <= dest_of(cur_ff)
                                             + {4'h0, idx_ff};
                            end
                            if ((st_ff == ST_TAG) && (mem_rdata_i != tag_exp))
                                pass_ff <= 1'b0;
                        end
                    endcase
                end
                ST_END:
                begin
                    auth_ff[cur_p_ff] <= pass_ff;
                    st_ff             <= ST_IDLE;
                end
                default:
                    st_ff <= ST_IDLE;
            endcase
        end
    end
end

endmodule

// File: sim/cdvu_ram_model.sv
// cdvu_ram_model.sv: byte RAM seen by the unit's memory port
// assumes one-cycle strobes; read data lands the cycle after mem_rd_o
`timescale 1ns/1ps
module cdvu_ram_model
(
    input  wire        clk_i,
    input  wire        rd_i,
    input  wire        wr_i,
    input  wire [11:0] addr_i,
    input  wire [7:0]  wdata_i,
    output reg  [7:0]  rdata_o
);
    reg [7:0] mem [0:767];
    integer   i;
    initial
    begin
        for (i = 0; i < 768; i = i + 1)
            mem[i] = i[7:0];
        rdata_o = 8'h00;
    end
    // data only valid after a strobe, toggles otherwise
    always @(posedge clk_i)
    begin
        if (wr_i && addr_i < 12'h300)
            mem[addr_i] <= wdata_i;
        if (rd_i && addr_i < 12'h300)
            rdata_o <= mem[addr_i];
        else
            rdata_o <= ~rdata_o;
    end
endmodule

// File: sim/cdvu_ccm_unit_monitor.sv
// cdvu_ccm_unit_monitor.sv: port checks of the decrypt-verify unit
// assumes bind onto cdvu_ccm_unit, one clock, active-low reset
`timescale 1ns/1ps
module cdvu_ccm_unit_monitor
(
    input wire        sys_clk_i,
    input wire        rst_b_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [31:0] prdata_o,
    input wire        mem_rd_o,
    input wire        mem_wr_o,
    input wire [11:0] mem_addr_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////
    property p_ready_after_setup;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    property p_ready_one;
        pready_o |=> !pready_o;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready longer than one cycle");
    property p_ready_cause;
        pready_o |-> penable_i && $past(psel_i && !penable_i);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without setup");
    property p_err_in_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_in_ready: assert property (p_err_in_ready)
        else $error("error outside access");
    property p_rdata_idle;
        !pready_o |-> prdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside access");
    ////////////////////////////////////////////////////////////////////
    property p_rd_spacing;
        mem_rd_o |=> !mem_rd_o [*2];
    endproperty
    a_rd_spacing: assert property (p_rd_spacing)
        else $error("read strobes too close");
    property p_wr_pulse;
        mem_wr_o |=> !mem_wr_o;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe too long");
    property p_mem_range;
        mem_rd_o || mem_wr_o |-> mem_addr_o < 12'h300;
    endproperty
    a_mem_range: assert property (p_mem_range)
        else $error("memory access out of range");
    property p_wr_from_rd;
        mem_wr_o |-> $past(mem_rd_o, 2);
    endproperty
    a_wr_from_rd: assert property (p_wr_from_rd)
        else $error("write without payload read");
endmodule
bind cdvu_ccm_unit cdvu_ccm_unit_monitor u_mon
(
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prdata_o(prdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o)
);

// File: sim/tb_cdvu_ccm_unit.sv
// tb_cdvu_ccm_unit.sv: self-checking bench of the decrypt-verify unit
// assumes cdvu_regs.vh map and the RAM model on the memory port
`timescale 1ns/1ps
`include "cdvu_regs.vh"
module tb_cdvu_ccm_unit;
    reg         sys_clk_i = 1'b0;
    reg         rst_b_i   = 1'b0;
    reg         sel_b     = 1'b1;
    reg         psel      = 1'b0;
    reg         penable   = 1'b0;
    reg         pwrite    = 1'b0;
    reg  [7:0]  paddr     = 8'h00;
    reg  [31:0] pwdata    = 32'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        mem_rd;
    wire        mem_wr;
    wire        irq;
    wire [11:0] mem_addr;
    wire [7:0]  mem_wdata;
    wire [7:0]  mem_rdata;
    integer     err_count = 0;
    integer     checked   = 0;
    integer     rd_cnt    = 0;
    integer     wr_cnt    = 0;
    integer     snap;
    reg  [11:0] rd_first;
    reg  [11:0] wr_first;
    reg  [31:0] rdat;
    reg         rerr;
    always #12.5 sys_clk_i = ~sys_clk_i;
    cdvu_ccm_unit dut
    (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .chip_select_active_low_i(sel_b), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
        .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata),
        .mem_rdata_i(mem_rdata), .irq_o(irq)
    );
    cdvu_ram_model u_ram
    (
        .clk_i(sys_clk_i), .rd_i(mem_rd), .wr_i(mem_wr),
        .addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata)
    );
    // memory strobe log
    always @(posedge sys_clk_i)
    begin
        if (mem_rd === 1'b1 && rd_cnt == 0)
            rd_first = mem_addr;
        if (mem_wr === 1'b1 && wr_cnt == 0)
            wr_first = mem_addr;
        rd_cnt = rd_cnt + (mem_rd === 1'b1);
        wr_cnt = wr_cnt + (mem_wr === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////
    task chk(input [8*8-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            $display("MISMATCH %0s exp %h got %h", nm, exp, got);
            err_count = err_count + 1;
        end
    end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
    begin
        @(posedge sys_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1)
            @(posedge sys_clk_i);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task issue(input [11:0] a, input [11:0] e, input [6:0] c,
               input [6:0] f, input [1:0] m, input p);
    begin
        apb(1'b1, `CDVU_ADDR_ARG0, {4'h0, e, 4'h0, a});
        apb(1'b1, `CDVU_ADDR_ARG1, {1'b0, f, 1'b0, c, 8'h02, 8'h01});
        apb(1'b1, `CDVU_ADDR_CMD, {26'h0, m, 1'b0, p, `CDVU_OP_CCM});
    end
    endtask
    task cmd_other(input [1:0] op, input [1:0] amask);
    begin
        apb(1'b1, `CDVU_ADDR_CMD, {22'h0, amask, 6'h00, op});
    end
    endtask
    task wait_stat(input [3:0] msk);
    begin
        rdat = 32'h0;
        while ((rdat[3:0] & msk) == 4'h0)
            apb(1'b0, `CDVU_ADDR_STAT, 32'h0);
    end
    endtask
    task fresh;
    begin
        apb(1'b1, `CDVU_ADDR_STAT, 32'h0000_000F);
        rd_cnt = 0;
        wr_cnt = 0;
    end
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_regs;
    begin
        apb(1'b0, `CDVU_ADDR_MASK, 32'h0);
        chk("mask", 32'h0, rdat);
        apb(1'b0, `CDVU_ADDR_STATE, 32'h0);
        chk("state", 32'h0, rdat);
        apb(1'b1, `CDVU_ADDR_ARG1, 32'h7F7F_FFFF);
        apb(1'b0, `CDVU_ADDR_ARG1, 32'h0);
        chk("arg1", 32'h7F7F_FFFF, rdat);
        apb(1'b0, `CDVU_ADDR_CMD, 32'h0);
        chk("cmd", 32'h0, rdat);
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
    end
    endtask
    task t_run(input [1:0] m, input p, input [6:0] f, input [6:0] c,
               input [11:0] e);
        integer tl;
    begin
        tl = (m == 2'h3) ? 16 : m * 4;
        fresh;
        issue(12'h100, e, c, f, m, p);
        wait_stat(4'h3);
        chk("done", p ? 32'h2 : 32'h1, rdat & 32'hF);
        chk("reads", 32 + f + c + tl, rd_cnt);
        chk("writes", c, wr_cnt);
        chk("keyaddr", 12'h010, rd_first);
        if (c != 0)
            chk("dest", e == 0 ? 12'h100 + f : e, wr_first);
        apb(1'b0, `CDVU_ADDR_STATE, 32'h0);
        if (m == 2'h0)
            chk("auth", 32'h1, p ? rdat[1] : rdat[0]);
    end
    endtask
    task t_misuse;
    begin
        fresh;
        issue(12'h000, 12'h000, 7'd64, 7'd65, 2'h0, 1'b0);
        wait_stat(4'hF);
        chk("sum129", 32'h4, rdat & 32'hF);
        fresh;
        issue(12'h000, 12'h000, 7'd20, 7'd100, 2'h0, 1'b1);
        issue(12'h000, 12'h000, 7'd1, 7'd0, 2'h0, 1'b1);
        wait_stat(4'h2);
        chk("busyprio", 32'h6, rdat & 32'hF);
        fresh;
        issue(12'h2F0, 12'h000, 7'd16, 7'd16, 2'h0, 1'b0);
        wait_stat(4'hF);
        apb(1'b0, `CDVU_ADDR_STAT, 32'h0);
        chk("badaddr", 32'h8, rdat & 32'hF);
        chk("skipped", 32'h0, rd_cnt);
    end
    endtask
    task t_abort;
    begin
        fresh;
        issue(12'h000, 12'h000, 7'd20, 7'd100, 2'h0, 1'b1);
        issue(12'h000, 12'h000, 7'd4, 7'd4, 2'h0, 1'b0);
        cmd_other(`CDVU_OP_ABORT, 2'b10);
        @(posedge sys_clk_i);
        snap = rd_cnt;
        repeat (30) @(posedge sys_clk_i);
        chk("stopped", snap, rd_cnt);
        apb(1'b0, `CDVU_ADDR_STATE, 32'h0);
        chk("flushed", 32'h0, rdat & 32'h1C);
        apb(1'b0, `CDVU_ADDR_STAT, 32'h0);
        chk("nodone", 32'h0, rdat & 32'hF);
        issue(12'h000, 12'h000, 7'd20, 7'd40, 2'h0, 1'b0);
        cmd_other(`CDVU_OP_ABORT, 2'b10);
        wait_stat(4'h1);
        chk("kept", 32'h1, rdat & 32'hF);
        fresh;
        issue(12'h000, 12'h000, 7'd20, 7'd40, 2'h0, 1'b0);
        cmd_other(`CDVU_OP_ABORT, 2'b01);
        apb(1'b0, `CDVU_ADDR_STATE, 32'h0);
        chk("lowstop", 32'h0, rdat & 32'h14);
    end
    endtask
    task t_irq;
    begin
        fresh;
        apb(1'b1, `CDVU_ADDR_MASK, 32'h1);
        issue(12'h100, 12'h000, 7'd1, 7'd0, 2'h0, 1'b0);
        wait_stat(4'h1);
        chk("irqon", 32'h1, irq);
        apb(1'b1, `CDVU_ADDR_STAT, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk("irqclr", 32'h0, irq);
        apb(1'b1, `CDVU_ADDR_MASK, 32'h0);
        issue(12'h100, 12'h000, 7'd1, 7'd0, 2'h0, 1'b0);
        wait_stat(4'h1);
        chk("irqmask", 32'h0, irq);
    end
    endtask
    task t_soft_reset_cmd;
    begin
        apb(1'b1, `CDVU_ADDR_MASK, 32'h0000_000F);
        @(posedge sys_clk_i);
        sel_b <= 1'b0;
        cmd_other(`CDVU_OP_SOFT_RESET_CMD, 2'b00);
        apb(1'b0, `CDVU_ADDR_MASK, 32'h0);
        chk("sresmask", 32'h0, rdat);
        apb(1'b1, `CDVU_ADDR_ARG0, 32'h0ABC_0123);
        cmd_other(`CDVU_OP_SOFT_RESET_CMD, 2'b00);
        apb(1'b0, `CDVU_ADDR_ARG0, 32'h0);
        chk("notfirst", 32'h0ABC_0123, rdat);
        sel_b <= 1'b1;
    end
    endtask
    task summarize;
    begin
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 20000);
        err_count = err_count + 1;
        summarize;
    end
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        t_regs;
        t_run(2'h0, 1'b0, 7'd3, 7'd5, 12'h000);
        t_run(2'h1, 1'b1, 7'd0, 7'd8, 12'h200);
        t_run(2'h2, 1'b0, 7'd64, 7'd64, 12'h000);
        t_run(2'h3, 1'b1, 7'd4, 7'd0, 12'h000);
        t_misuse;
        t_abort;
        t_irq;
        t_soft_reset_cmd;
        summarize;
    end
endmodule
